// File: tcd_top.v
// Threshold comparators and debounce filters with an APB register file
//
// How it works
// - Sample above high threshold sets comparator
// - Sample at or below low threshold clears
// - Warning B thresholds reset to 0x5A88
// - Warning C thresholds reset to 0x2D2D
// - Binary enable low forces comparator low
// - Bit 14 selects up/down, else up/clear
// - Length is bits 12:0, 20 us ticks
// - Glitches shorter than length are rejected in up/clear mode
// - Zero length bypasses the filter
// - Binary config resets to 0x0096
// - Warning configs reset to 0x80FA
// - Warning enable, mode bit, bit 13 zero
// - Hysteretic and midrange comparator modes
// - Greater-than and less-or-equal modes
`timescale 1ns/1ps
`include "tcd_map.vh"

module tcd_top #(
    parameter ADDR_W = 12,
    parameter LEN_W = 13,
    parameter TICK_W = 12
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // ADC sample stream
    input wire [7:0] adc_sample,
    input wire adc_valid,
    // Filtered outputs
    output reg channel_digital_output,
    output reg warning_a_out,
    output reg warning_b_out,
    output reg warning_c_out,
    // Interrupt
    output reg irq
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    // Full-width tick period, cut to the counter width on purpose
    localparam [31:0] TICK_LAST_FULL = `TCD_TICK_CYC - 1;
    localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_FULL[TICK_W-1:0];
    localparam NPATH = 4;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // Software-visible registers
    reg [15:0] thr_q [0:NPATH-1];
    reg [15:0] cfg_q [0:NPATH-1];
    reg [7:0] mode_q;
    reg [NPATH-1:0] status_q;
    reg [NPATH-1:0] mask_q;

    // Comparator and filter state, index 0 is the binary path
    reg [NPATH-1:0] cmp_q;
    reg [NPATH-1:0] cmp_d;
    reg [NPATH-1:0] filt_q;
    reg [NPATH-1:0] filt_d;
    reg [LEN_W-1:0] cnt_q [0:NPATH-1];
    reg [LEN_W-1:0] cnt_d [0:NPATH-1];

    // Timebase
    reg [TICK_W-1:0] tick_cnt_q;
    reg tick_q;

    // Bus side and edge detect
    reg [NPATH-1:0] rise_d;
    reg [31:0] rdata_d;
    reg hit_d;

    // One loop index per loop, none shared between processes, so no variable has two drivers
    integer i_cmp;
    integer i_flt;
    integer i_cnt;
    integer i_rst;
    integer i_sts;

    wire [9:0] reg_idx;
    wire acc;
    wire acc_wait;
    wire wr_en;
    wire sts_clr;
    wire [NPATH-1:0] pins;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Next comparator state from mode, thresholds and sample
    function cmp_next;
        input [1:0] mode;
        input [15:0] thr;
        input [7:0] s;
        input cur;
        reg [7:0] hi;
        reg [7:0] lo;
        begin
            hi = thr[`TCD_HI_MSB:`TCD_HI_LSB];
            lo = thr[`TCD_LO_MSB:`TCD_LO_LSB];
            case (mode)
                `TCD_MODE_HYST: begin
                    if (s > hi)
                        cmp_next = 1'b1;
                    else if (s <= lo)
                        cmp_next = 1'b0;
                    else
                        cmp_next = cur;
                end
                `TCD_MODE_MID: cmp_next = (s < hi) && (s > lo);
                `TCD_MODE_GT: cmp_next = (s > hi);
                `TCD_MODE_LT: cmp_next = (s <= hi);
                default: cmp_next = cur;
            endcase
        end
    endfunction

    // Configuration word as read back, reserved bit zero
    function [15:0] cfg_view;
        input [15:0] v;
        begin
            cfg_view = v & `TCD_CFG_WMASK;
        end
    endfunction

    // Debounce length field of a configuration word
    function [LEN_W-1:0] len_of;
        input [15:0] v;
        begin
            len_of = v[`TCD_LEN_MSB:`TCD_LEN_LSB];
        end
    endfunction

    // True when the debounce length is zero, filter bypassed
    function len_zero;
        input [15:0] v;
        begin
            len_zero = (len_of(v) == {LEN_W{1'b0}});
        end
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------

    // Word index and qualified access
    assign reg_idx = paddr[11:2];
    assign acc = psel && penable && pready;
    assign acc_wait = psel && penable && !pready;
    assign wr_en = acc && pwrite && hit_d;
    assign sts_clr = wr_en && (reg_idx == `TCD_IDX_STATUS);

    // Read mux and address hit
    always @* begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (reg_idx)
            `TCD_IDX_BIN_THR: rdata_d[15:0] = thr_q[0];
            `TCD_IDX_WA_THR: rdata_d[15:0] = thr_q[1];
            `TCD_IDX_WB_THR: rdata_d[15:0] = thr_q[2];
            `TCD_IDX_WC_THR: rdata_d[15:0] = thr_q[3];
            `TCD_IDX_BIN_CFG: rdata_d[15:0] = cfg_view(cfg_q[0]);
            `TCD_IDX_WA_CFG: rdata_d[15:0] = cfg_view(cfg_q[1]);
            `TCD_IDX_WB_CFG: rdata_d[15:0] = cfg_view(cfg_q[2]);
            `TCD_IDX_WC_CFG: rdata_d[15:0] = cfg_view(cfg_q[3]);
            `TCD_IDX_MODE: rdata_d[7:0] = mode_q;
            `TCD_IDX_STATUS: rdata_d[NPATH-1:0] = status_q;
            `TCD_IDX_MASK: rdata_d[NPATH-1:0] = mask_q;
            `TCD_IDX_OUTS: rdata_d[NPATH-1:0] = filt_q;
            default: hit_d = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------

    // One wait state, answer on the second access cycle
    always @(posedge core_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc_wait;
            pslverr <= acc_wait && !hit_d;
            if (acc_wait && !pwrite)
                prdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------

    // Thresholds, datapath configs, modes, mask
    always @(posedge core_clk) begin
        if (reset) begin
            thr_q[0] <= `TCD_RST_BIN_THR;
            thr_q[1] <= `TCD_RST_WA_THR;
            thr_q[2] <= `TCD_RST_WB_THR;
            thr_q[3] <= `TCD_RST_WC_THR;
            cfg_q[0] <= `TCD_RST_BIN_CFG;
            cfg_q[1] <= `TCD_RST_WARN_CFG;
            cfg_q[2] <= `TCD_RST_WARN_CFG;
            cfg_q[3] <= `TCD_RST_WARN_CFG;
            mode_q <= `TCD_RST_MODE;
            mask_q <= `TCD_RST_MASK;
        end else if (wr_en) begin
            case (reg_idx)
                `TCD_IDX_BIN_THR: thr_q[0] <= pwdata[15:0];
                `TCD_IDX_WA_THR: thr_q[1] <= pwdata[15:0];
                `TCD_IDX_WB_THR: thr_q[2] <= pwdata[15:0];
                `TCD_IDX_WC_THR: thr_q[3] <= pwdata[15:0];
                `TCD_IDX_BIN_CFG: cfg_q[0] <= cfg_view(pwdata[15:0]);
                `TCD_IDX_WA_CFG: cfg_q[1] <= cfg_view(pwdata[15:0]);
                `TCD_IDX_WB_CFG: cfg_q[2] <= cfg_view(pwdata[15:0]);
                `TCD_IDX_WC_CFG: cfg_q[3] <= cfg_view(pwdata[15:0]);
                `TCD_IDX_MODE: mode_q <= pwdata[7:0];
                `TCD_IDX_MASK: mask_q <= pwdata[NPATH-1:0];
                default: mask_q <= mask_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Debounce timebase
    // ------------------------------------------------------------

    // One-cycle tick every 20 us
    // Free-running: the first tick after a change may come early
    always @(posedge core_clk) begin
        if (reset) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= {TICK_W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------

    // Next comparator state; a disabled path reads low
    always @* begin
        for (i_cmp = 0; i_cmp < NPATH; i_cmp = i_cmp + 1) begin
            if (!cfg_q[i_cmp][`TCD_CFG_EN])
                cmp_d[i_cmp] = 1'b0;
            else if (adc_valid)
                cmp_d[i_cmp] = cmp_next(mode_q[2*i_cmp +: 2], thr_q[i_cmp], adc_sample,
                    cmp_q[i_cmp]);
            else
                cmp_d[i_cmp] = cmp_q[i_cmp];
        end
    end

    // Comparator flops, updated on each valid sample
    always @(posedge core_clk) begin
        if (reset)
            cmp_q <= {NPATH{1'b0}};
        else
            cmp_q <= cmp_d;
    end

    // ------------------------------------------------------------
    // Debounce filters
    // ------------------------------------------------------------

    // Next counter and output per path
    always @* begin
        for (i_flt = 0; i_flt < NPATH; i_flt = i_flt + 1) begin
            filt_d[i_flt] = filt_q[i_flt];
            cnt_d[i_flt] = cnt_q[i_flt];
            if (i_flt != 0 && !cfg_q[i_flt][`TCD_CFG_EN]) begin
                filt_d[i_flt] = 1'b0;
                cnt_d[i_flt] = {LEN_W{1'b0}};
            end else if (len_zero(cfg_q[i_flt])) begin
                filt_d[i_flt] = cmp_q[i_flt];
                cnt_d[i_flt] = {LEN_W{1'b0}};
            end else if (tick_q) begin
                if (cmp_q[i_flt] != filt_q[i_flt]) begin
                    if (cnt_q[i_flt] + 1'b1 >= len_of(cfg_q[i_flt])) begin
                        filt_d[i_flt] = cmp_q[i_flt];
                        cnt_d[i_flt] = {LEN_W{1'b0}};
                    end else begin
                        cnt_d[i_flt] = cnt_q[i_flt] + 1'b1;
                    end
                end else if (cfg_q[i_flt][`TCD_CFG_UPDN]) begin
                    if (cnt_q[i_flt] != {LEN_W{1'b0}})
                        cnt_d[i_flt] = cnt_q[i_flt] - 1'b1;
                end else begin
                    cnt_d[i_flt] = {LEN_W{1'b0}};
                end
            end
        end
    end

    // Filter flops
    always @(posedge core_clk) begin
        if (reset) begin
            filt_q <= {NPATH{1'b0}};
            for (i_rst = 0; i_rst < NPATH; i_rst = i_rst + 1)
                cnt_q[i_rst] <= {LEN_W{1'b0}};
        end else begin
            filt_q <= filt_d;
            for (i_cnt = 0; i_cnt < NPATH; i_cnt = i_cnt + 1)
                cnt_q[i_cnt] <= cnt_d[i_cnt];
        end
    end

    // ------------------------------------------------------------
    // Outputs and interrupt
    // ------------------------------------------------------------

    // Pins as a vector, in path order
    assign pins = {warning_c_out, warning_b_out, warning_a_out, channel_digital_output};

    // Rising edges of filtered outputs, seen one cycle before the pins move
    always @* begin
        rise_d = filt_q & ~pins;
    end

    // Pins mirror the filter flops, one cycle later
    always @(posedge core_clk) begin
        if (reset) begin
            channel_digital_output <= 1'b0;
            warning_a_out <= 1'b0;
            warning_b_out <= 1'b0;
            warning_c_out <= 1'b0;
        end else begin
            channel_digital_output <= filt_q[0];
            warning_a_out <= filt_q[1];
            warning_b_out <= filt_q[2];
            warning_c_out <= filt_q[3];
        end
    end

    // Sticky status, write one to clear, set wins over a clear in the same cycle
    always @(posedge core_clk) begin
        if (reset) begin
            status_q <= {NPATH{1'b0}};
        end else begin
            for (i_sts = 0; i_sts < NPATH; i_sts = i_sts + 1) begin
                if (rise_d[i_sts])
                    status_q[i_sts] <= 1'b1;
                else if (sts_clr && pwdata[i_sts])
                    status_q[i_sts] <= 1'b0;
            end
        end
    end

    // Level interrupt, high while an unmasked status bit is set
    always @(posedge core_clk) begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(status_q & mask_q);
    end

endmodule

// File: tcd_map.vh
// Register map, field layout and timing constants of the threshold/debounce block
`ifndef TCD_MAP_VH
`define TCD_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCD_IDX_BIN_THR 10'h003
`define TCD_IDX_WA_THR 10'h004
`define TCD_IDX_WB_THR 10'h005
`define TCD_IDX_WC_THR 10'h006
`define TCD_IDX_BIN_CFG 10'h007
`define TCD_IDX_WA_CFG 10'h008
`define TCD_IDX_WB_CFG 10'h009
`define TCD_IDX_WC_CFG 10'h00A
`define TCD_IDX_MODE 10'h010
`define TCD_IDX_STATUS 10'h011
`define TCD_IDX_MASK 10'h012
`define TCD_IDX_OUTS 10'h013

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TCD_RST_BIN_THR 16'h5AAA
`define TCD_RST_WA_THR 16'hCCCC
`define TCD_RST_WB_THR 16'h5A88
`define TCD_RST_WC_THR 16'h2D2D
`define TCD_RST_BIN_CFG 16'h0096
`define TCD_RST_WARN_CFG 16'h80FA
`define TCD_RST_MODE 8'h08
`define TCD_RST_MASK 4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCD_HI_MSB 7
`define TCD_HI_LSB 0
`define TCD_LO_MSB 15
`define TCD_LO_LSB 8
`define TCD_CFG_EN 15
`define TCD_CFG_UPDN 14
`define TCD_CFG_RSVD 13
`define TCD_LEN_MSB 12
`define TCD_LEN_LSB 0
`define TCD_CFG_WMASK 16'hDFFF

// ----------------------------------------------------------------
// Comparator modes
// ----------------------------------------------------------------
`define TCD_MODE_HYST 2'h0
`define TCD_MODE_MID 2'h1
`define TCD_MODE_GT 2'h2
`define TCD_MODE_LT 2'h3

// ----------------------------------------------------------------
// Debounce timebase
// ----------------------------------------------------------------
`define TCD_TICK_NS 20000
`define TCD_CLK_NS 10
`define TCD_TICK_CYC (`TCD_TICK_NS / `TCD_CLK_NS)

`endif

// File: tcd_chk_asserts.sv
// Checker for the threshold/debounce block's APB port and outputs
`timescale 1ns/1ps
module tcd_chk #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input logic core_clk,
    input logic reset,
    // APB
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // Filtered outputs and interrupt
    input logic channel_digital_output,
    input logic warning_a_out,
    input logic warning_b_out,
    input logic warning_c_out,
    input logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_quiet;
        disable iff (1'b0) reset |=> !(channel_digital_output || warning_a_out
            || warning_b_out || warning_c_out || irq);
    endproperty
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    property p_pair;
        pready |-> psel && penable;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    property p_err_zero;
        pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    property p_upper_zero;
        pready && !pwrite |-> prdata[31:16] == 16'h0;
    endproperty
    property p_rsvd;
        pready && !pwrite && paddr[ADDR_W-1:2] >= 10'h007
            && paddr[ADDR_W-1:2] <= 10'h00A |-> !prdata[13];
    endproperty
    a_quiet: assert property (p_quiet) else $error("output high out of reset");
    a_answer: assert property (p_answer) else $error("late ready");
    a_pair: assert property (p_pair) else $error("ready outside access");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
    // Main scenarios reached
    c_err: cover property (pready && pslverr);
    c_warn: cover property ($rose(warning_b_out));
    c_irq: cover property ($rose(irq));
    c_bin: cover property ($rose(channel_digital_output));
endmodule
bind tcd_top tcd_chk #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_digital_output(channel_digital_output),
    .warning_a_out(warning_a_out), .warning_b_out(warning_b_out),
    .warning_c_out(warning_c_out), .irq(irq));

// File: tcd_adc_model.sv
// ADC sample source feeding the comparators
`timescale 1ns/1ps
module tcd_adc_model #(
    parameter GAP = 3
) (
    // Clock
    input logic core_clk,
    // Level to sample
    input logic [7:0] level,
    // Sample stream
    output logic [7:0] adc_sample,
    output logic adc_valid
);
    int cnt = 0;
    // One sample every GAP cycles, junk data in between
    always @(posedge core_clk) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        adc_valid <= (cnt == 0);
        adc_sample <= (cnt == 0) ? level : ~adc_sample;
    end
endmodule

// File: tb.sv
// Testbench for the threshold/debounce block
`timescale 1ns/1ps
module tb;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, adc_valid, er;
    logic cdo, wa, wb, wc, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] adc_sample, lvl;
    int mismatches = 0;
    int checks_done = 0;
    int wt;
    logic [15:0] rv [6] = '{16'h5A88, 16'h2D2D, 16'h0096, 16'h80FA, 16'h80FA, 16'h80FA};
    logic [15:0] mt [7] = '{16'h1301, 16'h1400, 16'h1200, 16'h2411, 16'h2400, 16'h3401,
        16'h3410};
    tcd_top DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .channel_digital_output(cdo), .warning_a_out(wa), .warning_b_out(wb),
        .warning_c_out(wc), .irq(irq));
    tcd_adc_model #(.GAP(3)) u_adc (.core_clk(core_clk), .level(lvl),
        .adc_sample(adc_sample), .adc_valid(adc_valid));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ------------------------------------------------
    // Compare, bus and stimulus tasks
    // ------------------------------------------------
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_pin(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [9:0] i, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        if (n >= 50) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [9:0] i, input logic [15:0] d);
        apb(1'b1, i, d);
    endtask
    task rd_chk(input logic [9:0] i, input logic [31:0] e);
        apb(1'b0, i, 16'h0000);
        chk_reg(rd, e);
    endtask
    task put(input logic [7:0] v, input int n);
        lvl <= v;
        repeat (n) @(posedge core_clk);
    endtask
    task wrap_up;
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        wrap_up;
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lvl = 8'h20;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rd_chk(10'h005 + i, {16'h0, rv[i]});
        apb(1'b0, 10'h3FF, 16'h0000);
        chk_pin(er, 1'b1);
        wr(10'h009, 16'hA000);
        rd_chk(10'h009, 32'h00008000);
        wr(10'h008, 16'h0000);
        wr(10'h00A, 16'h8000);
        for (int i = 3; i < 7; i++) wr(i[9:0], 16'h2040);
        wr(10'h012, 16'h0004);
        put(8'h41, 12);
        chk_pin(wb, 1'b1);
        chk_pin(wa, 1'b0);
        chk_pin(irq, 1'b1);
        put(8'h30, 12);
        chk_pin(wb, 1'b1);
        put(8'h21, 12);
        chk_pin(wb, 1'b1);
        put(8'h20, 12);
        chk_pin(wb, 1'b0);
        rd_chk(10'h011, 32'h0000000C);
        wr(10'h011, 16'h0004);
        rd_chk(10'h011, 32'h00000008);
        chk_pin(irq, 1'b0);
        for (int i = 0; i < 7; i++) begin
            wr(10'h010, {8'h00, mt[i][13:12], 6'h08});
            put(mt[i][11:4], 12);
            chk_pin(wc, mt[i][0]);
        end
        put(8'h41, 50);
        chk_pin(cdo, 1'b0);
        put(8'h20, 20);
        wr(10'h007, 16'h8002);
        put(8'h41, 1500);
        put(8'h20, 100);
        chk_pin(cdo, 1'b0);
        put(8'h41, 6000);
        chk_pin(cdo, 1'b1);
        wr(10'h007, 16'hC002);
        rd_chk(10'h007, 32'h0000C002);
        put(8'h20, 1500);
        put(8'h41, 4100);
        chk_pin(cdo, 1'b1);
        put(8'h20, 6000);
        chk_pin(cdo, 1'b0);
        // Lock to the tick phase through a length-one warning B path
        wr(10'h007, 16'hC003);
        wr(10'h009, 16'h8001);
        wr(10'h005, 16'h0810);
        wt = 0;
        while (wb !== 1'b1 && wt < 2100) begin
            @(posedge core_clk);
            wt++;
        end
        chk_pin(wb, 1'b1);
        // Mid-period from here: each 2000-cycle step holds exactly one tick
        repeat (1000) @(posedge core_clk);
        put(8'h41, 4000);
        chk_pin(cdo, 1'b0);
        put(8'h20, 2000);
        put(8'h41, 4000);
        chk_pin(cdo, 1'b1);
        rd_chk(10'h013, 32'h00000005);
        rd_chk(10'h011, 32'h0000000D);
        chk_pin(irq, 1'b1);
        wrap_up;
    end
endmodule
